// ===== src/i2c_irq_pkg.sv
// Shared offsets, field positions, reset values and types of the controller.
package i2c_irq_pkg;

  // Register offsets.
  localparam logic [2:0] OFS_OWN_ADDR = 3'h0;
  localparam logic [2:0] OFS_RATE = 3'h1;
  localparam logic [2:0] OFS_CTL = 3'h2;
  localparam logic [2:0] OFS_FLAGS = 3'h3;
  localparam logic [2:0] OFS_DATA = 3'h4;

  // Reset values.
  localparam logic [7:0] RST_OWN_ADDR = 8'h00;
  localparam logic [7:0] RST_RATE = 8'h00;
  localparam logic [7:0] RST_DATA = 8'h00;

  // Control register fields.
  localparam int CTL_EN = 7;
  localparam int CTL_IE = 6;
  localparam int CTL_MST = 5;
  localparam int CTL_TX = 4;
  localparam int CTL_NOACK = 3;
  localparam int CTL_REPEAT_START_REQUEST = 2;

  // Flag register fields.
  localparam int FLG_DONE = 7;
  localparam int FLG_AAS = 6;
  localparam int FLG_BUSY = 5;
  localparam int FLG_ARB = 4;
  localparam int FLG_SDIR = 2;
  localparam int FLG_IRQ = 1;
  localparam int FLG_RXACK = 0;

  // Rate register fields and divider step.
  localparam int RATE_MUL_HI = 7;
  localparam int RATE_MUL_LO = 6;
  localparam int RATE_DIV_HI = 5;
  localparam int DIV_STEP = 8;

  // Bit counts within one byte transfer.
  localparam logic [3:0] TOP_BIT = 4'h7;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h9;

  // One register access from software.
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage

// ===== src/pin_sync.sv
// Two-stage synchroniser for the bus pins.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pins and synchronised levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;

  // An idle bus floats high, so both stages reset high.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_q <= '1;
      dout <= '1;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule // pin_sync
`default_nettype wire

// ===== src/scl_rate_gen.sv
// Half-period tick generator for the serial clock.
`timescale 1ns/1ps
`default_nettype none
module scl_rate_gen
  import i2c_irq_pkg::*;
#(
  parameter int CNT_W = 12
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Rate setting and restart
  input wire logic [7:0] rate_sel,
  input wire logic restart,
  // Half-period strobe
  output logic tick
);
  logic [CNT_W-1:0] cnt_q;
  wire logic [1:0] mul_code = rate_sel[RATE_MUL_HI:RATE_MUL_LO];
  wire logic [CNT_W-1:0] div_val =
    CNT_W'((rate_sel[RATE_DIV_HI:0] + 7'h01) * DIV_STEP);
  wire logic [CNT_W-1:0] half = (mul_code == 2'h0) ? div_val :
    (mul_code == 2'h1) ? {div_val[CNT_W-2:0], 1'b0} :
    {div_val[CNT_W-3:0], 2'b00};

  // One half period is multiplier times divider system clocks.
  assign tick = (cnt_q == half);

  always_ff @(posedge sys_clk) begin
    if (rst || restart || tick) begin
      cnt_q <= CNT_W'(1);
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  tick_min_a: assert property (
    restart ##1 !restart [*3] |-> !tick)
    else $error("half period shorter than the smallest divider");
  tick_gap_a: assert property (
    tick && !restart |=> !tick)
    else $error("ticks on back to back cycles");
endmodule // scl_rate_gen
`default_nettype wire

// ===== src/i2c_irq_status_ctrl.sv
// Two-wire bus controller with status flags and one interrupt.
`timescale 1ns/1ps
`default_nettype none
module i2c_irq_status_ctrl
  import i2c_irq_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire reg_req_t reg_req,
  output logic [7:0] rd_data,
  // Serial clock pin
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  // Serial data pin
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // Interrupt request
  output logic irq
);
  typedef enum {m_idle, m_start, m_low, m_high, m_hold,
                m_rs1, m_rs2, m_stop1, m_stop2} mstate_t;

  mstate_t state_q, state_d;
  logic [7:0] own_addr_q, rate_q, tx_data_q, rx_data_q, shift_q;
  logic [7:0] ctl_rd, flg_rd;
  logic [3:0] bit_cnt_q;
  logic [1:0] pins_s;
  logic en_q, ie_q, mst_q, tx_q, noack_q, repeat_start_request_q;
  logic done_q, aas_q, busy_q, arb_q, sdir_q, iflag_q, rxack_q;
  logic addr_ph_q, slv_act_q, own_hi_q, scl_p_q, sda_p_q;
  logic sda_low_d, own_hi_d, tick;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and bus conditions.
  pin_sync #(.W(2)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .din({scl_i, sda_i}),
    .dout(pins_s)
  );

  wire logic scl_s = pins_s[1];
  wire logic sda_s = pins_s[0];
  wire logic scl_rise = scl_s && !scl_p_q;
  wire logic scl_fall = !scl_s && scl_p_q;
  wire logic start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
  wire logic stop_det = scl_s && scl_p_q && !sda_p_q && sda_s;

  //////////////////////////////////////////////////////////////////////////
  // Register decode.
  wire logic [7:0] wd = reg_req.wdata;
  wire logic wr_own = reg_req.wr && (reg_req.addr == OFS_OWN_ADDR);
  wire logic wr_rate = reg_req.wr && (reg_req.addr == OFS_RATE);
  wire logic wr_ctl = reg_req.wr && (reg_req.addr == OFS_CTL);
  wire logic wr_flg = reg_req.wr && (reg_req.addr == OFS_FLAGS);
  wire logic wr_dat = reg_req.wr && (reg_req.addr == OFS_DATA);
  wire logic rd_dat = reg_req.rd && (reg_req.addr == OFS_DATA);
  wire logic rd_flg = reg_req.rd && (reg_req.addr == OFS_FLAGS);

  //////////////////////////////////////////////////////////////////////////
  // Arbitration and event sources.
  wire logic arb_bit = scl_rise && mst_q && own_hi_q && !sda_s;
  wire logic arb_stop = stop_det && mst_q;
  wire logic start_busy = wr_ctl && wd[CTL_MST] && !mst_q && busy_q;
  wire logic repeat_start_request_bad = wr_ctl && wd[CTL_REPEAT_START_REQUEST] && !mst_q;
  wire logic arb_set = en_q &&
    (arb_bit || arb_stop || start_busy || repeat_start_request_bad);

  wire logic last_bit = (bit_cnt_q == LAST_BIT);
  wire logic part = mst_q || slv_act_q;
  wire logic match_now = scl_fall && addr_ph_q && !mst_q &&
    (bit_cnt_q == DATA_BITS) && (shift_q[7:1] == own_addr_q[7:1]);
  wire logic done_set = en_q && scl_fall && last_bit && part;
  wire logic aas_set = en_q && match_now;
  wire logic irq_set = done_set || aas_set || arb_set;

  // Which party owns SDA in the bit that follows this falling edge.
  wire logic addr_nx = addr_ph_q && !last_bit;
  wire logic [3:0] nb = last_bit ? 4'h0 : bit_cnt_q;
  wire logic xmit = addr_nx ? mst_q :
    (mst_q ? tx_q : (slv_act_q && sdir_q && rxack_q));
  wire logic tx_bit = tx_data_q[3'(TOP_BIT - nb)];
  wire logic hold_bit = last_bit && mst_q;
  wire logic data_slot = (nb < DATA_BITS);
  wire logic ack_by_us = addr_nx ? match_now : (!xmit && part);
  wire logic fall_low = !hold_bit && (data_slot ? (xmit && !tx_bit) :
    (ack_by_us && (addr_nx || !noack_q)));
  wire logic fall_hi = !hold_bit && mst_q && (data_slot ?
    (xmit && tx_bit) : (!addr_nx && !xmit && noack_q));
  wire logic rx_cap = done_set && !addr_ph_q && !(mst_q ? tx_q : sdir_q);

  //////////////////////////////////////////////////////////////////////////
  // Control register next values.
  wire logic en_d = wr_ctl ? wd[CTL_EN] : en_q;
  wire logic mst_d = en_d && !arb_set &&
    (wr_ctl ? (wd[CTL_MST] && (mst_q || !busy_q)) : mst_q);
  wire logic repeat_start_request_d = mst_d &&
    ((wr_ctl && wd[CTL_REPEAT_START_REQUEST]) || (repeat_start_request_q && state_d != m_start));

  //////////////////////////////////////////////////////////////////////////
  // Master sequencer.
  always_comb begin
    state_d = state_q;
    case (state_q)
      m_idle: if (mst_q && wr_dat && !busy_q) state_d = m_start;
      m_start: if (tick) state_d = m_low;
      m_low: if (tick) state_d = m_high;
      m_high: if (tick && scl_s) state_d = last_bit ? m_hold : m_low;
      m_hold: begin
        if (!mst_q) begin
          state_d = m_stop1;
        end else if (repeat_start_request_q && wr_dat) begin
          state_d = m_rs1;
        end else if (tx_q ? wr_dat : rd_dat) begin
          state_d = m_low;
        end
      end
      m_rs1: if (tick) state_d = m_rs2;
      m_rs2: if (tick && scl_s) state_d = m_start;
      m_stop1: if (tick) state_d = m_stop2;
      m_stop2: if (tick && scl_s) state_d = m_idle;
      default: state_d = m_idle;
    endcase
    if (!en_q || arb_set) state_d = m_idle;
  end

  wire logic scl_low_d = (state_d == m_low) || (state_d == m_hold) ||
    (state_d == m_rs1) || (state_d == m_stop1);
  wire logic wait_high = (state_q == m_high) || (state_q == m_rs2) ||
    (state_q == m_stop2);
  wire logic restart = !en_q || (state_d != state_q) || (wait_high && !scl_s);

  scl_rate_gen #(.CNT_W(12)) u_rate (
    .sys_clk(sys_clk),
    .rst(rst),
    .rate_sel(rate_q),
    .restart(restart),
    .tick(tick)
  );

  // SDA drive: sequencer conditions first, then the per-bit engine.
  always_comb begin
    sda_low_d = !sda_oe_n;
    own_hi_d = own_hi_q;
    if (!en_q || arb_set) begin
      sda_low_d = 1'b0;
      own_hi_d = 1'b0;
    end else if (state_d == m_start || state_d == m_stop1) begin
      sda_low_d = 1'b1;
      own_hi_d = 1'b0;
    end else if (state_d == m_rs1 || state_q == m_stop2) begin
      sda_low_d = state_q == m_stop2 && state_d == m_stop2;
      own_hi_d = 1'b0;
    end else if (state_q == m_hold && state_d == m_low) begin
      sda_low_d = tx_q && !wd[7];
      own_hi_d = tx_q && wd[7];
    end else if ((start_det || stop_det) && !mst_q) begin
      sda_low_d = 1'b0;
      own_hi_d = 1'b0;
    end else if (scl_fall) begin
      sda_low_d = fall_low;
      own_hi_d = fall_hi;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus tracking and control registers.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      busy_q <= en_q && (start_det || (busy_q && !stop_det));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      own_addr_q <= RST_OWN_ADDR;
      rate_q <= RST_RATE;
      {en_q, ie_q, tx_q, noack_q, mst_q, repeat_start_request_q} <= 6'h00;
    end else begin
      if (wr_own) own_addr_q <= {wd[7:1], 1'b0};
      if (wr_rate) rate_q <= wd;
      if (wr_ctl) begin
        {en_q, ie_q, noack_q} <= {wd[CTL_EN], wd[CTL_IE], wd[CTL_NOACK]};
      end
      tx_q <= !arb_set && (wr_ctl ? wd[CTL_TX] : tx_q);
      mst_q <= mst_d;
      repeat_start_request_q <= repeat_start_request_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status flags; a set in the same cycle as a clear wins.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {done_q, aas_q, arb_q, iflag_q, sdir_q, irq} <= 6'h00;
    end else begin
      done_q <= done_set || (done_q && en_q && !(wr_dat || rd_dat));
      aas_q <= aas_set || (aas_q && en_q && !wr_ctl);
      arb_q <= arb_set || (arb_q && !(wr_flg && wd[FLG_ARB]));
      iflag_q <= irq_set || (iflag_q && !(wr_flg && wd[FLG_IRQ]));
      if (aas_set) sdir_q <= shift_q[0];
      irq <= iflag_q && ie_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Byte engine, following the bus clock whoever drives it.
  always_ff @(posedge sys_clk) begin
    if (rst || !en_q) begin
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      {addr_ph_q, slv_act_q, rxack_q} <= 3'h0;
    end else begin
      if (start_det || stop_det) begin
        bit_cnt_q <= 4'h0;
        addr_ph_q <= start_det;
        slv_act_q <= 1'b0;
      end else if (scl_rise && !last_bit) begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
        if (bit_cnt_q < DATA_BITS) begin
          shift_q <= {shift_q[6:0], sda_s};
        end else begin
          rxack_q <= !sda_s;
        end
      end else if (scl_fall && last_bit) begin
        bit_cnt_q <= 4'h0;
        addr_ph_q <= 1'b0;
      end
      if (match_now) slv_act_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_data_q <= RST_DATA;
      rx_data_q <= RST_DATA;
    end else begin
      if (wr_dat) tx_data_q <= wd;
      if (rx_cap) rx_data_q <= shift_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data and pin outputs.
  always_comb begin
    ctl_rd = 8'h00;
    ctl_rd[CTL_EN] = en_q;
    ctl_rd[CTL_IE] = ie_q;
    ctl_rd[CTL_MST] = mst_q;
    ctl_rd[CTL_TX] = tx_q;
    ctl_rd[CTL_NOACK] = noack_q;
    flg_rd = 8'h00;
    flg_rd[FLG_DONE] = done_q;
    flg_rd[FLG_AAS] = aas_q;
    flg_rd[FLG_BUSY] = busy_q;
    flg_rd[FLG_ARB] = arb_q;
    flg_rd[FLG_SDIR] = sdir_q;
    flg_rd[FLG_IRQ] = iflag_q;
    flg_rd[FLG_RXACK] = rxack_q;
  end

  wire logic [7:0] rd_mux =
    (reg_req.addr == OFS_OWN_ADDR) ? own_addr_q :
    (reg_req.addr == OFS_RATE) ? rate_q :
    (reg_req.addr == OFS_CTL) ? ctl_rd :
    (reg_req.addr == OFS_FLAGS) ? flg_rd :
    (reg_req.addr == OFS_DATA) ? rx_data_q : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= m_idle;
      own_hi_q <= 1'b0;
      {scl_oe_n, sda_oe_n} <= 2'h3;
      {scl_o, sda_o} <= 2'h0;
      rd_data <= 8'h00;
    end else begin
      state_q <= state_d;
      own_hi_q <= own_hi_d;
      scl_oe_n <= !scl_low_d;
      sda_oe_n <= !sda_low_d;
      {scl_o, sda_o} <= 2'h0;
      rd_data <= reg_req.rd ? rd_mux : 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_pending;
    iflag_q && ie_q;
  endsequence

  irq_level_a: assert property (s_pending |=> irq)
    else $error("interrupt missing while flag and enable set");
  irq_held_a: assert property (
    s_pending ##1 s_pending |=> irq && $past(irq))
    else $error("interrupt level dropped early");
  flag_w1c_a: assert property (
    iflag_q && !(wr_flg && wd[FLG_IRQ]) |=> iflag_q)
    else $error("combined flag cleared without a one written");
  src_sets_a: assert property (irq_set |=> iflag_q)
    else $error("source event did not set the combined flag");
  done_ninth_a: assert property (
    $rose(done_q) |-> $past(scl_fall && last_bit))
    else $error("byte done not at ninth falling edge");
  match_flag_a: assert property (
    aas_set |=> aas_q && slv_act_q && sdir_q == $past(shift_q[0]))
    else $error("address match not recorded");
  arb_bit_a: assert property (
    en_q && arb_bit |=> arb_q && !mst_q && sda_oe_n && state_q == m_idle)
    else $error("lost bit did not release the bus");
  ack_hi_a: assert property (
    scl_fall && mst_q && !hold_bit && !data_slot && !addr_nx && !xmit &&
    noack_q && en_q && !arb_set && state_d == state_q |=> own_hi_q)
    else $error("master receiver high acknowledge not watched");
  start_busy_a: assert property (
    en_q && start_busy |=> arb_q && !mst_q)
    else $error("start on busy bus not refused");
  repeat_start_request_slave_a: assert property (
    en_q && repeat_start_request_bad |=> arb_q && !repeat_start_request_q)
    else $error("repeated start in slave mode not refused");
  stray_stop_a: assert property (
    en_q && stop_det && mst_q |=> arb_q && !mst_q)
    else $error("foreign stop not treated as loss");
  arb_sticky_a: assert property (
    arb_q && !(wr_flg && wd[FLG_ARB]) |=> arb_q)
    else $error("arbitration flag cleared without a one written");
  start_cause_a: assert property (
    $past(state_q == m_idle) && state_q == m_start |->
    $past(wr_dat && mst_q))
    else $error("transaction began without a data write");
  read_flags_a: assert property (
    rd_flg && done_q && arb_q |=> rd_data[FLG_DONE] && rd_data[FLG_ARB])
    else $error("status read hides a source bit");
  idle_release_a: assert property (
    !en_q [*2] |-> scl_oe_n && sda_oe_n)
    else $error("disabled controller drives the bus");
endmodule // i2c_irq_status_ctrl
`default_nettype wire

// ===== testbench/bus_peer.sv
// Peer on the two-wire bus: one addressed slave and a task-driven master.
`timescale 1ns/1ps
`default_nettype none
module bus_peer #(
  parameter logic [6:0] ADDR = 7'h3a,
  parameter int HP = 2000
) (
  // Bus levels
  input wire logic scl,
  input wire logic sda,
  // Releases, high when let go
  output logic scl_rel,
  output logic sda_rel
);
  logic m_scl = 1'b1;
  logic m_sda = 1'b1;
  logic s_sda = 1'b1;
  logic hit;
  logic first;
  logic [7:0] rx;
  assign scl_rel = m_scl;
  assign sda_rel = m_sda & s_sda;
  ////////////////////////////////////////////////////////////////////////////
  // The slave acknowledges its write address and the bytes that follow.
  always @(negedge sda) begin : frame
    if (scl === 1'b1) begin
      hit = 1'b0;
      first = 1'b1;
      forever begin
        repeat (8) begin
          @(posedge scl);
          rx = {rx[6:0], sda};
          @(negedge scl);
        end
        if (first) hit = rx == {ADDR, 1'b0};
        first = 1'b0;
        s_sda = !hit;
        @(negedge scl);
        s_sda = 1'b1;
      end
    end
  end
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      disable frame;
      s_sda = 1'b1;
    end
  end
  task automatic m_start();
    m_sda = 1'b0;
    #HP m_scl = 1'b0;
    #HP;
  endtask
  task automatic m_byte(input logic [7:0] b, output logic ack);
    for (int k = 7; k >= 0; k--) begin
      m_sda = b[k];
      #HP m_scl = 1'b1;
      #HP m_scl = 1'b0;
    end
    m_sda = 1'b1;
    #HP m_scl = 1'b1;
    ack = !sda;
    #HP m_scl = 1'b0;
  endtask
  task automatic m_stop();
    m_sda = 1'b0;
    #HP m_scl = 1'b1;
    #HP m_sda = 1'b1;
    #HP;
  endtask
endmodule // bus_peer
`default_nettype wire

// ===== testbench/i2c_irq_status_ctrl_test.sv
// Self-checking bench for the controller's flags, interrupt and bus use.
`timescale 1ns/1ps
`default_nettype none
module i2c_irq_status_ctrl_test;
  import i2c_irq_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  reg_req_t reg_req = '0;
  logic [7:0] rd_data;
  logic scl_o, scl_oe_n, sda_o, sda_oe_n, irq;
  wire scl_rel;
  wire sda_rel;
  wire scl_line = ~(scl_oe_n === 1'b0 && scl_o === 1'b0) & scl_rel;
  wire sda_line = ~(sda_oe_n === 1'b0 && sda_o === 1'b0) & sda_rel;
  int err_total = 0;
  int n_tests = 0;
  int rises = 0;
  int stops = 0;
  realtime t_last = 0;
  realtime t_prev = 0;
  i2c_irq_status_ctrl uut (.sys_clk(sys_clk), .rst(rst), .reg_req(reg_req),
    .rd_data(rd_data), .scl_i(scl_line), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .irq(irq));
  bus_peer #(.ADDR(7'h3a), .HP(2000)) peer (.scl(scl_line), .sda(sda_line),
    .scl_rel(scl_rel), .sda_rel(sda_rel));
  initial forever #25 sys_clk = ~sys_clk;
  always @(posedge scl_line) begin
    t_prev = t_last;
    t_last = $realtime;
    rises++;
  end
  always @(posedge sda_line) if (scl_line === 1'b1) stops++;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    reg_req <= '0;
  endtask
  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    reg_req <= '0;
    #1 d = rd_data;
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [7:0] m,
                       input logic [7:0] exp, input string what);
    logic [7:0] v;
    reg_rd(a, v);
    chk(what, exp, v & m);
  endtask
  task automatic irq_is(input logic lvl, input int n);
    for (int i = 0; i < n && irq !== lvl; i++) @(posedge sys_clk);
    #1 chk("irq", {7'h00, lvl}, {7'h00, irq});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    for (int a = 0; a < 8; a++) rdchk(3'(a), 8'hff, 8'h00, "reset");
    chk("pins", 8'h06, {5'h00, scl_oe_n, sda_oe_n, irq});
    reg_wr(3'h5, 8'hff);
    rdchk(3'h5, 8'hff, 8'h00, "unmapped");
    reg_wr(OFS_OWN_ADDR, 8'h5b);
    rdchk(OFS_OWN_ADDR, 8'hff, 8'h5a, "own address");
    $display("reset test done");
  endtask
  task automatic test_master(input logic [7:0] rate, input int h);
    int p;
    int s0;
    reg_wr(OFS_RATE, rate);
    reg_wr(OFS_CTL, 8'hc0);
    reg_wr(OFS_CTL, 8'hd0);
    reg_wr(OFS_CTL, 8'hf0);
    repeat (20) @(posedge sys_clk);
    chk("idle", 8'h03, {6'h00, scl_oe_n, sda_oe_n});
    rises = 0;
    reg_wr(OFS_DATA, {7'h3a, 1'b0});
    irq_is(1'b1, 40 * h);
    p = int'((t_last - t_prev) / 50.0);
    chk("scl rises", 8'h09, 8'(rises));
    chk("scl period", 8'h01, {7'h00, p >= 2 * h && p <= 2 * h + 4});
    rdchk(OFS_FLAGS, 8'hff, 8'ha3, "flags");
    reg_wr(OFS_FLAGS, 8'h00);
    irq_is(1'b1, 2);
    reg_wr(OFS_FLAGS, 8'h02);
    repeat (2) @(posedge sys_clk);
    irq_is(1'b0, 0);
    s0 = stops;
    reg_wr(OFS_CTL, 8'hd0);
    for (int i = 0; i < 8 * h && stops == s0; i++) @(posedge sys_clk);
    chk("stop", 8'h01, {7'h00, stops != s0});
    reg_wr(OFS_CTL, 8'h00);
    $display("master test done");
  endtask
  task automatic test_arb_bit();
    reg_wr(OFS_RATE, 8'h41);
    reg_wr(OFS_CTL, 8'hd0);
    reg_wr(OFS_CTL, 8'hf0);
    reg_wr(OFS_DATA, 8'ha0);
    @(negedge scl_line);
    peer.m_sda = 1'b0;
    irq_is(1'b1, 2000);
    chk("sda freed", 8'h01, {7'h00, sda_oe_n});
    rdchk(OFS_FLAGS, 8'hff, 8'h32, "flags");
    rdchk(OFS_CTL, 8'hff, 8'hc0, "control");
    peer.m_sda = 1'b1;
    reg_wr(OFS_FLAGS, 8'h00);
    rdchk(OFS_FLAGS, 8'hff, 8'h12, "flags");
    reg_wr(OFS_FLAGS, 8'h12);
    rdchk(OFS_FLAGS, 8'hff, 8'h00, "flags");
    $display("bit arbitration test done");
  endtask
  task automatic test_arb_cmd();
    peer.m_start();
    reg_wr(OFS_CTL, 8'he0);
    rdchk(OFS_FLAGS, 8'hff, 8'h32, "flags");
    peer.m_stop();
    reg_wr(OFS_FLAGS, 8'h12);
    reg_wr(OFS_CTL, 8'hc4);
    rdchk(OFS_FLAGS, 8'hff, 8'h12, "flags");
    rdchk(OFS_CTL, 8'hff, 8'hc0, "control");
    reg_wr(OFS_FLAGS, 8'h12);
    $display("command arbitration test done");
  endtask
  task automatic test_slave();
    logic ack;
    reg_wr(OFS_OWN_ADDR, 8'h5a);
    reg_wr(OFS_CTL, 8'hc0);
    peer.m_start();
    peer.m_byte(8'h22, ack);
    peer.m_stop();
    chk("foreign ack", 8'h00, {7'h00, ack});
    irq_is(1'b0, 0);
    peer.m_start();
    peer.m_byte(8'h5a, ack);
    chk("own ack", 8'h01, {7'h00, ack});
    irq_is(1'b1, 0);
    rdchk(OFS_FLAGS, 8'h7e, 8'h62, "flags");
    reg_wr(OFS_CTL, 8'hc0);
    reg_wr(OFS_FLAGS, 8'h02);
    peer.m_byte(8'h3c, ack);
    chk("data ack", 8'h01, {7'h00, ack});
    // The ninth falling edge reaches the flags only after the pin stages.
    repeat (4) @(posedge sys_clk);
    rdchk(OFS_FLAGS, 8'h82, 8'h82, "flags");
    rdchk(OFS_DATA, 8'hff, 8'h3c, "data");
    peer.m_stop();
    reg_wr(OFS_CTL, 8'h00);
    $display("slave test done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    test_reset();
    test_master(8'h00, 8);
    test_master(8'h82, 96);
    test_arb_bit();
    test_arb_cmd();
    test_slave();
    complete_run();
  end
  initial begin
    #3_000_000;
    err_total++;
    complete_run();
  end
endmodule // i2c_irq_status_ctrl_test
`default_nettype wire
